/* File: shared/ncd_pkg.sv */
// package: register map, field positions and constants of the oscillator sync and decimator block
package ncd_pkg;
	// printed offsets 0x300.. are not multiples of four: they are indices, byte address = 4*index
	localparam logic [11:0] IDX_MODE_CONTROL = 12'h300; // mode control index
	localparam logic [11:0] IDX_OSC_CONTROL  = 12'h301; // oscillator control index
	localparam logic [11:0] IDX_SYNC_MASK    = 12'h302; // sync window mask index
	localparam logic [11:0] IDX_PHASE_OFFSET = 12'h303; // phase offset index
	localparam logic [11:0] IDX_TUNING_WORD  = 12'h304; // tuning word index
	localparam logic [11:0] IDX_DEC_RATIO    = 12'h305; // decimation ratio index
	localparam logic [11:0] IDX_DEC_ATTEN    = 12'h306; // decimator attenuation index
	localparam logic [11:0] IDX_STATUS       = 12'h307; // status index (read only)
	// field positions
	localparam int MODE_SYNC_MASTER_BIT = 3; // sync master select
	localparam int MODE_DIVERSITY_BIT   = 1; // diversity real input mode
	localparam int OSC_PHASE_DITHER_BIT = 1; // phase dither enable
	localparam int OSC_AMP_DITHER_BIT   = 2; // amplitude dither enable
	// reset values
	localparam logic [7:0]  MODE_RESET     = 8'h08; // master after reset
	localparam logic [7:0]  OSC_RESET      = 8'h00;
	localparam logic [31:0] SYNC_MASK_RESET = 32'hFFFFFFFF;
	localparam logic [15:0] PHASE_OFF_RESET = 16'h0000;
	localparam logic [31:0] TUNING_RESET   = 32'h00000000;
	localparam logic [4:0]  RATIO_RESET    = 5'h01;
	localparam logic [2:0]  ATTEN_RESET    = 3'h0;
	localparam logic [4:0]  RATIO_MIN      = 5'h01;
	localparam logic [4:0]  RATIO_MAX      = 5'h10;
	localparam logic [2:0]  ATTEN_MAX      = 3'h6;
	localparam logic [15:0] DITHER_SEED    = 16'hACE1; // lfsr seed, any value other than 16'h0000 and 16'hFFFF (lfsr_a starts from its inverse)
	localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
	localparam logic [1:0]  HTRANS_SEQ     = 2'h3;
endpackage : ncd_pkg

/* File: design/ncd_top.sv */
// design: oscillator phase logic with sync pin, and second-order decimator, behind an ahb-lite slave
// Operation
// (RQ1) control bit 1 enables phase dither
// (RQ2) control bit 2 enables amplitude dither
// (RQ3) both dithers enable independently
// (RQ4) sixteen-bit phase offset added to accumulator
// (RQ5) master drives sync pulse on clock edge
// (RQ6) slave samples sync input every clock
// (RQ7) slave holds oscillator while sync high
// (RQ8) external source holds sync proper sample periods
// (RQ9) mask sets sync window and aligned msbs
// (RQ10) software programs same all-ones mask everywhere
// (RQ11) oscillator advances every clock channel-select high
// (RQ12) tuning word access forces oscillator sync
// (RQ13) slave tuning write forces no sync
// (RQ14) new master syncs at next zero phase
// (RQ15) decimator ratio one to sixteen
// (RQ16) i and q parallel, then multiplexed out
// (RQ17) second-order cic, gain over two^(s+2)
// (RQ18) attenuation zero to six, 6 dB steps
// (RQ19) attenuation applied even when ratio one
// (RQ20) decimator keeps up with input rate
// (RQ21) software picks smallest safe attenuation
// (RQ22) tuning word is 32-bit phase increment
// (RQ23) diversity mode shares oscillator words
// (RQ24) dither lfsrs advance per oscillator update
`timescale 1ns/10ps
module ncd_top
(
	input  wire logic        MCLK,        // processing clock, 20 MHz
	input  wire logic        RSTN,        // asynchronous reset, active low
	input  wire logic        HSEL,        // ahb-lite slave select
	input  wire logic [31:0] HADDR,       // byte address
	input  wire logic [1:0]  HTRANS,      // transfer type
	input  wire logic        HWRITE,      // write when high
	input  wire logic [2:0]  HSIZE,       // transfer size
	input  wire logic [31:0] HWDATA,      // write data
	input  wire logic        HREADY,      // bus ready in
	output logic      [31:0] HRDATA,      // read data
	output logic             HREADYOUT,   // slave ready
	output logic             HRESP,       // always okay
	input  wire logic        SYNC_IN,     // sync pin input level
	output logic             SYNC_OUT,    // sync pin output level
	output logic             SYNC_OE,     // sync pin driven while high
	input  wire logic        CHAN_SEL,    // channel-select input, sample strobe
	input  wire logic [15:0] DATA_I,      // translated i sample
	input  wire logic [15:0] DATA_Q,      // translated q sample
	output logic      [31:0] OSC_PHASE,   // dithered, offset oscillator phase
	output logic      [1:0]  AMP_DITHER,  // amplitude dither bits for the converter
	output logic      [15:0] DEC_DATA,    // multiplexed decimator output
	output logic             DEC_VALID,   // output word valid pulse
	output logic             DEC_IS_I     // high for i word, low for q word
);
	// registers
	logic [7:0]  mode_control;          // mode control
	logic [7:0]  oscillator_control;    // dither enables
	logic [31:0] sync_window_mask_reg;  // sync window mask
	logic [15:0] phase_offset;          // phase offset
	logic [31:0] tuning_word;           // phase increment
	logic [4:0]  decimation_ratio;      // decimator ratio
	logic [2:0]  decimator_attenuation; // decimator scale
	// bus state
	logic        dp_active;             // data phase pending
	logic        dp_write;              // pending is a write
	logic [11:0] dp_index;              // pending register index
	logic        tuning_access;         // one-cycle pulse on tuning word access
	logic        bad_addr;              // address outside register block
	// oscillator state
	logic [31:0] acc;                   // phase accumulator
	logic [15:0] lfsr_p;                // phase dither source
	logic [15:0] lfsr_a;                // amplitude dither source
	logic        sync_s;                // sampled sync input
	logic        is_master;             // sync master select
	logic        master_q;              // master bit one cycle earlier
	logic        rearm;                 // waiting for zero phase after slave to master
	logic        advance;               // oscillator update this cycle
	logic [31:0] next_acc;              // accumulator after advance
	logic        in_window;             // phase within sync window
	logic        zero_cross;            // accumulator wrapped this advance
	// decimator state
	logic [37:0] int1_i, int2_i, int1_q, int2_q;  // integrators
	logic [37:0] comb1_i, comb2_i, comb1_q, comb2_q; // comb delays
	logic [4:0]  dec_cnt;               // input samples in current output
	logic        q_pending;             // q word waits for the next cycle
	logic [15:0] q_hold;                // held q word

	assign is_master = mode_control[ncd_pkg::MODE_SYNC_MASTER_BIT];
	assign bad_addr  = HADDR[31:14] != 18'h00000 || HADDR[1:0] != 2'h0;

	// address phase capture; this slave never waits so hreadyout stays high
	always_ff @(posedge MCLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			dp_active <= 1'b0;
			dp_write  <= 1'b0;
			dp_index  <= 12'h000;
		end
		else if (HREADY)
		begin
			dp_active <= HSEL && (HTRANS == ncd_pkg::HTRANS_NONSEQ || HTRANS == ncd_pkg::HTRANS_SEQ);
			dp_write  <= HWRITE;
			dp_index  <= bad_addr ? 12'hFFF : HADDR[13:2];
		end
	end

	// fixed handshake: zero wait states, okay response
	always_ff @(posedge MCLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
		end
		else
		begin
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
		end
	end

	// read data is registered at the address phase so it stands in the data phase
	always_ff @(posedge MCLK or negedge RSTN)
	begin
		if (!RSTN)
			HRDATA <= 32'h00000000;
		else if (HREADY && HSEL && !HWRITE && HTRANS[1] && !bad_addr)
		begin
			if (HADDR[13:2] == ncd_pkg::IDX_MODE_CONTROL)
				HRDATA <= {24'h000000, mode_control};
			else if (HADDR[13:2] == ncd_pkg::IDX_OSC_CONTROL)
				HRDATA <= {24'h000000, oscillator_control};
			else if (HADDR[13:2] == ncd_pkg::IDX_SYNC_MASK)
				HRDATA <= sync_window_mask_reg;
			else if (HADDR[13:2] == ncd_pkg::IDX_PHASE_OFFSET)
				HRDATA <= {16'h0000, phase_offset};
			else if (HADDR[13:2] == ncd_pkg::IDX_TUNING_WORD)
				HRDATA <= tuning_word;
			else if (HADDR[13:2] == ncd_pkg::IDX_DEC_RATIO)
				HRDATA <= {27'h0000000, decimation_ratio};
			else if (HADDR[13:2] == ncd_pkg::IDX_DEC_ATTEN)
				HRDATA <= {29'h00000000, decimator_attenuation};
			else if (HADDR[13:2] == ncd_pkg::IDX_STATUS)
				HRDATA <= {29'h00000000, rearm, sync_s, is_master}; // own state
			else
				HRDATA <= 32'h00000000; // unmapped reads zero
		end
		else
			HRDATA <= 32'h00000000;
	end

	// register writes in the data phase
	always_ff @(posedge MCLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			mode_control          <= ncd_pkg::MODE_RESET;
			oscillator_control    <= ncd_pkg::OSC_RESET;
			sync_window_mask_reg  <= ncd_pkg::SYNC_MASK_RESET;
			phase_offset          <= ncd_pkg::PHASE_OFF_RESET;
			tuning_word           <= ncd_pkg::TUNING_RESET;
			decimation_ratio      <= ncd_pkg::RATIO_RESET;
			decimator_attenuation <= ncd_pkg::ATTEN_RESET;
		end
		else if (dp_active && dp_write)
		begin
			if (dp_index == ncd_pkg::IDX_MODE_CONTROL)
				mode_control <= HWDATA[7:0];
			else if (dp_index == ncd_pkg::IDX_OSC_CONTROL)
				oscillator_control <= HWDATA[7:0]; // RQ1 RQ2 RQ3
			else if (dp_index == ncd_pkg::IDX_SYNC_MASK)
				sync_window_mask_reg <= HWDATA; // RQ9
			else if (dp_index == ncd_pkg::IDX_PHASE_OFFSET)
				phase_offset <= HWDATA[15:0]; // RQ4
			else if (dp_index == ncd_pkg::IDX_TUNING_WORD)
				tuning_word <= HWDATA; // RQ22
			else if (dp_index == ncd_pkg::IDX_DEC_RATIO)
			begin
				// out-of-range ratios are clamped into 1..16
				if (HWDATA[4:0] < ncd_pkg::RATIO_MIN)
					decimation_ratio <= ncd_pkg::RATIO_MIN;
				else if (HWDATA[31:5] != 27'h0000000 || HWDATA[4:0] > ncd_pkg::RATIO_MAX)
					decimation_ratio <= ncd_pkg::RATIO_MAX;
				else
					decimation_ratio <= HWDATA[4:0]; // RQ15
			end
			else if (dp_index == ncd_pkg::IDX_DEC_ATTEN)
				// out-of-range scales, high bits included, are clamped to six
				decimator_attenuation <= (HWDATA[31:3] != 29'h00000000
					|| HWDATA[2:0] > ncd_pkg::ATTEN_MAX)
					? ncd_pkg::ATTEN_MAX : HWDATA[2:0]; // RQ18
		end
	end

	// any read or write of the tuning word, as a master, forces an oscillator sync
	always_ff @(posedge MCLK or negedge RSTN)
	begin
		if (!RSTN)
			tuning_access <= 1'b0;
		else
			tuning_access <= dp_active && dp_index == ncd_pkg::IDX_TUNING_WORD
				&& is_master; // RQ12 RQ13
	end

	// sync pin sampling; inputs are synchronous so one stage suffices
	always_ff @(posedge MCLK or negedge RSTN)
	begin
		if (!RSTN)
			sync_s <= 1'b0;
		else
			sync_s <= SYNC_IN && !is_master; // RQ6
	end

	// oscillator advances on the channel-select strobe, held while slave sync stands high
	assign advance    = CHAN_SEL && !(sync_s && !is_master); // RQ11 RQ7
	assign next_acc   = acc + tuning_word; // RQ22
	assign zero_cross = next_acc < acc;
	// window: phase bits outside the mask ignored, near zero crossing
	assign in_window  = (acc & sync_window_mask_reg) == 32'h00000000
		|| ((acc + tuning_word) & sync_window_mask_reg) == 32'h00000000; // RQ9

	// accumulator: cleared by forced sync, masked bits cleared by slave sync, otherwise advance
	always_ff @(posedge MCLK or negedge RSTN)
	begin
		if (!RSTN)
			acc <= 32'h00000000;
		else if (tuning_access)
			acc <= 32'h00000000; // RQ12
		else if (sync_s && !is_master)
			acc <= acc & ~sync_window_mask_reg; // RQ7 RQ9
		else if (advance)
			acc <= next_acc;
	end

	// returning to master arms a sync for the next zero crossing
	always_ff @(posedge MCLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			master_q <= 1'b1;
			rearm    <= 1'b0;
		end
		else
		begin
			master_q <= is_master;
			if (is_master && !master_q)
				rearm <= 1'b1; // RQ14
			else if (!is_master || (advance && zero_cross))
				rearm <= 1'b0;
		end
	end

	// sync pin drive: one-cycle pulse on forced sync, or on a wrap inside the window or while re-armed
	always_ff @(posedge MCLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			SYNC_OUT <= 1'b0;
			SYNC_OE  <= 1'b0;
		end
		else
		begin
			SYNC_OE  <= is_master; // RQ5 RQ6
			SYNC_OUT <= is_master && (tuning_access
				|| (advance && zero_cross && (in_window || rearm))); // RQ5 RQ14
		end
	end

	// dither sources step once per oscillator update
	always_ff @(posedge MCLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			lfsr_p <= ncd_pkg::DITHER_SEED;
			lfsr_a <= ~ncd_pkg::DITHER_SEED;
		end
		else if (advance)
		begin
			lfsr_p <= {lfsr_p[14:0], lfsr_p[15] ^ lfsr_p[13] ^ lfsr_p[12] ^ lfsr_p[10]}; // RQ24
			lfsr_a <= {lfsr_a[14:0], lfsr_a[15] ^ lfsr_a[13] ^ lfsr_a[12] ^ lfsr_a[10]}; // RQ24
		end
	end

	// phase out: offset in top bits, dither in the truncated bits; one word serves both channels
	always_ff @(posedge MCLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			OSC_PHASE  <= 32'h00000000;
			AMP_DITHER <= 2'h0;
		end
		else
		begin
			OSC_PHASE <= acc + {phase_offset, 16'h0000} // RQ4 RQ23
				+ (oscillator_control[ncd_pkg::OSC_PHASE_DITHER_BIT]
				? {16'h0000, lfsr_p} : 32'h00000000); // RQ1 RQ3
			AMP_DITHER <= oscillator_control[ncd_pkg::OSC_AMP_DITHER_BIT]
				? lfsr_a[1:0] : 2'h0; // RQ2 RQ3
		end
	end

	// integrators run every input sample, i and q in parallel
	always_ff @(posedge MCLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			int1_i <= '0;
			int2_i <= '0;
			int1_q <= '0;
			int2_q <= '0;
		end
		else if (CHAN_SEL)
		begin
			int1_i <= int1_i + {{22{DATA_I[15]}}, DATA_I}; // RQ16 RQ17 RQ20
			int2_i <= int2_i + int1_i + {{22{DATA_I[15]}}, DATA_I};
			int1_q <= int1_q + {{22{DATA_Q[15]}}, DATA_Q};
			int2_q <= int2_q + int1_q + {{22{DATA_Q[15]}}, DATA_Q};
		end
	end

	// combs run at the output rate; wraparound arithmetic keeps the cic exact
	always_ff @(posedge MCLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			dec_cnt   <= 5'h01;
			comb1_i   <= '0;
			comb2_i   <= '0;
			comb1_q   <= '0;
			comb2_q   <= '0;
			DEC_DATA  <= 16'h0000;
			DEC_VALID <= 1'b0;
			DEC_IS_I  <= 1'b0;
			q_pending <= 1'b0;
			q_hold    <= 16'h0000;
		end
		else if (CHAN_SEL && dec_cnt >= decimation_ratio)
		begin
			dec_cnt <= 5'h01; // RQ15
			comb1_i <= int2_i + int1_i + {{22{DATA_I[15]}}, DATA_I};
			comb2_i <= int2_i + int1_i + {{22{DATA_I[15]}}, DATA_I} - comb1_i;
			comb1_q <= int2_q + int1_q + {{22{DATA_Q[15]}}, DATA_Q};
			comb2_q <= int2_q + int1_q + {{22{DATA_Q[15]}}, DATA_Q} - comb1_q;
			// second comb output scaled by 2^-(s+2), ratio one too; the shift is four bits
			// wide because six plus two would wrap to zero in three bits
			DEC_DATA  <= 16'((int2_i + int1_i + {{22{DATA_I[15]}}, DATA_I} - comb1_i - comb2_i)
				>>> ({1'b0, decimator_attenuation} + 4'h2)); // RQ17 RQ18 RQ19
			q_hold    <= 16'((int2_q + int1_q + {{22{DATA_Q[15]}}, DATA_Q} - comb1_q - comb2_q)
				>>> ({1'b0, decimator_attenuation} + 4'h2));
			DEC_VALID <= 1'b1;
			DEC_IS_I  <= 1'b1;
			q_pending <= 1'b1; // RQ16
		end
		else
		begin
			if (CHAN_SEL)
				dec_cnt <= dec_cnt + 5'h01;
			DEC_VALID <= q_pending;
			DEC_IS_I  <= 1'b0;
			if (q_pending)
				DEC_DATA <= q_hold; // RQ16
			q_pending <= 1'b0;
		end
	end
endmodule : ncd_top

/* File: sim/ncd_sync_src.sv */
// partner model: external sync source driving the sync pin of a slave
`timescale 1ns/10ps
module ncd_sync_src
(
	input  wire logic       MCLK,  // processing clock
	input  wire logic       RSTN,  // asynchronous reset, active low
	input  wire logic       start, // one-cycle request for a sync level
	input  wire logic [3:0] len,   // clocks the level is held high
	output logic            drv    // level this source puts on the pin
);
	logic [3:0] cnt; // clocks of high level still to go
	// hold the level a whole number of clocks, never a glitch
	always_ff @(posedge MCLK or negedge RSTN)
	begin
		if (!RSTN)
			cnt <= 4'h0;
		else if (start)
			cnt <= len;
		else if (cnt != 4'h0)
			cnt <= cnt - 4'h1;
	end
	assign drv = (cnt != 4'h0);
endmodule : ncd_sync_src

/* File: sim/ncd_props.sv */
// checker: bus, sync pin and decimator output relations at the top ports
`timescale 1ns/10ps
module ncd_props
(
	input wire logic        MCLK,
	input wire logic        RSTN,
	input wire logic        HSEL,
	input wire logic [1:0]  HTRANS,
	input wire logic        HREADY,
	input wire logic [31:0] HRDATA,
	input wire logic        HREADYOUT,
	input wire logic        HRESP,
	input wire logic        SYNC_IN,
	input wire logic        SYNC_OUT,
	input wire logic        SYNC_OE,
	input wire logic        CHAN_SEL,
	input wire logic [31:0] OSC_PHASE,
	input wire logic        DEC_VALID,
	input wire logic        DEC_IS_I
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RSTN);
	// zero-wait slave, never an error
	AST_READY: assert property (HREADYOUT) else $error("slave stalled");
	AST_RESP: assert property (!HRESP) else $error("error response");
	// read data only in a data phase, so a stale word cannot leak
	AST_RDZERO: assert property (!$past(HSEL && HTRANS[1] && HREADY) |-> HRDATA == 32'h0)
		else $error("read data outside data phase");
	AST_SYNC_PULSE: assert property (SYNC_OUT |=> !SYNC_OUT)
		else $error("sync pulse too long");
	AST_SYNC_MASTER: assert property (SYNC_OUT |-> SYNC_OE)
		else $error("sync pulse while not driving");
	// a held slave keeps its phase frozen
	AST_SLAVE_HOLD: assert property ((!SYNC_OE && SYNC_IN && CHAN_SEL) [*4] |=> $stable(OSC_PHASE))
		else $error("phase moved while held");
	AST_IQ_ORDER: assert property (DEC_VALID && DEC_IS_I |=> DEC_VALID && !DEC_IS_I)
		else $error("i word not followed by q");
	AST_FIRST_I: assert property ($rose(DEC_VALID) |-> DEC_IS_I)
		else $error("output burst not opened by i");
	AST_ISI_VALID: assert property (DEC_IS_I |-> DEC_VALID)
		else $error("i flag without valid");
	AST_DEC_CAUSE: assert property (DEC_VALID && DEC_IS_I |-> $past(CHAN_SEL))
		else $error("output without input sample");
endmodule : ncd_props
bind ncd_top ncd_props u_props (.MCLK, .RSTN, .HSEL, .HTRANS, .HREADY, .HRDATA, .HREADYOUT,
	.HRESP, .SYNC_IN, .SYNC_OUT, .SYNC_OE, .CHAN_SEL, .OSC_PHASE, .DEC_VALID, .DEC_IS_I);

/* File: sim/nco_sync_and_second_order_decimator_decimator_test.sv */
// testbench: registers, oscillator sync and dither, decimator outputs
`timescale 1ns/10ps
`define CHK(a,b) begin tests_run++; if ((a) !== (b)) begin err_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module nco_sync_and_second_order_decimator_decimator_test;
	logic        MCLK, RSTN, HSEL, HWRITE, CHAN_SEL, src_go;
	logic [31:0] HADDR, HWDATA, HRDATA, OSC_PHASE, rd, base;
	logic [1:0]  HTRANS, AMP_DITHER;
	logic [2:0]  HSIZE;
	logic [15:0] DATA_I, DATA_Q, DEC_DATA;
	logic        HREADYOUT, HRESP, SYNC_OUT, SYNC_OE, DEC_VALID, DEC_IS_I;
	logic        src_drv, sync_pin, amp_seen, ph_seen, sync_seen;
	logic [16:0] q[$], e17;   // notes of expected {is_i, word}
	int          err_count, tests_run, seed, x, y, m, s, out_cnt;
	int          ms[4] = '{1, 4, 16, 5}; // ratio 1 still runs through the cic and scale
	int          ss[4] = '{0, 2, 6, 3}; // smallest safe scale per ratio
	// pin level: device when it drives, else the external source
	assign sync_pin = SYNC_OE ? SYNC_OUT : src_drv;
	ncd_top dut (.MCLK, .RSTN, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
		.HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .SYNC_IN(sync_pin), .SYNC_OUT,
		.SYNC_OE, .CHAN_SEL, .DATA_I, .DATA_Q, .OSC_PHASE, .AMP_DITHER, .DEC_DATA,
		.DEC_VALID, .DEC_IS_I);
	ncd_sync_src u_src (.MCLK, .RSTN, .start(src_go), .len(4'h6), .drv(src_drv));
	initial
	begin
		MCLK = 1'b0;
		forever #25 MCLK = ~MCLK;
	end
	task give_verdict;
		if (err_count == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict
	// wait for hready under a bound, a hang ends the run
	task wait_rdy;
		int n;
		n = 0;
		do begin @(posedge MCLK); n++; end while (HREADYOUT !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			err_count++;
			give_verdict();
		end
	endtask : wait_rdy
	task bus(input logic w, input logic [11:0] idx, input logic [31:0] wd);
		@(posedge MCLK);
		HSEL <= 1'b1;
		HTRANS <= ncd_pkg::HTRANS_NONSEQ;
		HADDR <= {18'h0, idx, 2'h0}; // index times four
		HWRITE <= w;
		wait_rdy();
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= wd;
		wait_rdy();
		rd = HRDATA;
	endtask : bus
	task rdc(input logic [11:0] idx, input logic [31:0] e);
		bus(1'b0, idx, 32'h0);
		`CHK(rd, e)
	endtask : rdc
	task idle(input int n);
		repeat (n) @(posedge MCLK);
	endtask : idle
	// channel select high for n clocks in a row
	task adv(input int n);
		repeat (n) @(posedge MCLK) CHAN_SEL <= 1'b1;
		@(posedge MCLK) CHAN_SEL <= 1'b0;
	endtask : adv
	// one sample every other clock, legal for every ratio
	task feed(input int n);
		repeat (n)
		begin
			@(posedge MCLK) CHAN_SEL <= 1'b1;
			@(posedge MCLK) CHAN_SEL <= 1'b0;
		end
	endtask : feed
	task osc(input logic [31:0] e);
		idle(4);
		@(negedge MCLK);
		`CHK(OSC_PHASE, e)
	endtask : osc
	// output watcher, sampled mid-cycle where everything has settled
	always @(negedge MCLK)
	begin
		if (AMP_DITHER !== 2'h0) amp_seen = 1'b1;
		if (OSC_PHASE !== base) ph_seen = 1'b1;
		if (SYNC_OUT === 1'b1) sync_seen = 1'b1;
		if (DEC_VALID === 1'b1 && DEC_IS_I === 1'b1) out_cnt++;
		if (DEC_VALID === 1'b1 && q.size() > 0)
		begin
			e17 = q.pop_front();
			`CHK({DEC_IS_I, DEC_DATA}, e17)
		end
	end
	initial
	begin
		{RSTN, HSEL, HWRITE, CHAN_SEL, src_go, amp_seen, ph_seen, sync_seen} = 8'h0;
		{HADDR, HWDATA, base, HTRANS, DATA_I, DATA_Q} = '0;
		HSIZE = 3'h2;
		seed = 32'he295;
		repeat (5) @(posedge MCLK);
		RSTN <= 1'b1;
		rdc(ncd_pkg::IDX_MODE_CONTROL, 32'h8);
		rdc(ncd_pkg::IDX_STATUS, 32'h1);
		rdc(ncd_pkg::IDX_OSC_CONTROL, 32'h0);
		rdc(ncd_pkg::IDX_SYNC_MASK, 32'hFFFFFFFF);
		rdc(ncd_pkg::IDX_DEC_ATTEN, 32'h0);
		bus(1'b1, ncd_pkg::IDX_SYNC_MASK, 32'hFFFFFFFF);
		bus(1'b1, ncd_pkg::IDX_DEC_RATIO, 32'h1F);
		rdc(ncd_pkg::IDX_DEC_RATIO, 32'h10);
		bus(1'b1, ncd_pkg::IDX_DEC_RATIO, 32'h0);
		rdc(ncd_pkg::IDX_DEC_RATIO, 32'h1);
		bus(1'b1, ncd_pkg::IDX_DEC_ATTEN, 32'h7);
		rdc(ncd_pkg::IDX_DEC_ATTEN, 32'h6);
		bus(1'b1, 12'h308, 32'hFFFFFFFF);
		rdc(12'h308, 32'h0);
		bus(1'b1, ncd_pkg::IDX_DEC_RATIO, 32'h2);
		x = $random(seed);
		base = {x[15:0], 16'h0};
		bus(1'b1, ncd_pkg::IDX_PHASE_OFFSET, {16'h0, x[15:0]});
		rdc(ncd_pkg::IDX_PHASE_OFFSET, {16'h0, x[15:0]});
		bus(1'b1, ncd_pkg::IDX_TUNING_WORD, 32'h00100000);
		idle(3);
		adv(5);
		osc(base + 32'h00500000);
		rdc(ncd_pkg::IDX_TUNING_WORD, 32'h00100000);
		osc(base);
		// slave: tuning write keeps phase, held sync masks it to zero
		bus(1'b1, ncd_pkg::IDX_MODE_CONTROL, 32'h0);
		rdc(ncd_pkg::IDX_STATUS, 32'h0);
		adv(3);
		bus(1'b1, ncd_pkg::IDX_TUNING_WORD, 32'h00100000);
		osc(base + 32'h00300000);
		@(posedge MCLK) src_go <= 1'b1;
		@(posedge MCLK) src_go <= 1'b0;
		adv(6);
		osc(base);
		`CHK(SYNC_OE, 1'b0)
		// back to master away from zero; the wrap skips zero, so only the re-arm can pulse
		bus(1'b1, ncd_pkg::IDX_TUNING_WORD, 32'h50000000);
		adv(1);
		bus(1'b1, ncd_pkg::IDX_MODE_CONTROL, 32'h8);
		rdc(ncd_pkg::IDX_STATUS, 32'h5);
		sync_seen = 1'b0;
		adv(6);
		idle(3);
		`CHK(sync_seen, 1'b1)
		`CHK(SYNC_OE, 1'b1)
		for (int c = 0; c < 8; c += 2)
		begin
			bus(1'b1, ncd_pkg::IDX_OSC_CONTROL, c);
			bus(1'b1, ncd_pkg::IDX_TUNING_WORD, 32'h0);
			idle(4);
			{amp_seen, ph_seen} = 2'h0;
			adv(12);
			idle(2);
			`CHK(amp_seen, c[2])
			`CHK(ph_seen, c[1])
		end
		bus(1'b1, ncd_pkg::IDX_OSC_CONTROL, 32'h0);
		// constant input: settled output is m*m*x scaled by 2^-(s+2)
		for (int k = 0; k < 4; k++)
		begin
			m = ms[k];
			s = ss[k];
			bus(1'b1, ncd_pkg::IDX_DEC_RATIO, m);
			bus(1'b1, ncd_pkg::IDX_DEC_ATTEN, s);
			x = $random(seed) % 2048;
			y = $random(seed) % 2048;
			DATA_I <= x[15:0];
			DATA_Q <= y[15:0];
			feed(3 * m + 2);
			idle(4);
			repeat (2)
			begin
				q.push_back({1'b1, 16'((m * m * x) >>> (s + 2))});
				q.push_back({1'b0, 16'((m * m * y) >>> (s + 2))});
			end
			out_cnt = 0;
			feed(2 * m);
			idle(6);
			`CHK(out_cnt, 2)
		end
		// reset in mid-run: registers and sync state return to their reset values
		@(posedge MCLK) RSTN <= 1'b0;
		@(posedge MCLK) RSTN <= 1'b1;
		rdc(ncd_pkg::IDX_DEC_RATIO, 32'h1);
		rdc(ncd_pkg::IDX_STATUS, 32'h1);
		give_verdict();
	end
endmodule : nco_sync_and_second_order_decimator_decimator_test
